// *** inc/timer16_pkg.sv ***
// timer16_pkg: shared constants for the byte-access 16-bit timer
// assumes: both ends, the checker and the bench import it; the link interface does not
package timer16_pkg;
  // byte locations on the 8-bit timer bus
  localparam logic [3:0] loc_count_lo = 4'h0;
  localparam logic [3:0] loc_count_hi = 4'h1;
  localparam logic [3:0] loc_cmpa_lo = 4'h2;
  localparam logic [3:0] loc_cmpa_hi = 4'h3;
  localparam logic [3:0] loc_cmpb_lo = 4'h4;
  localparam logic [3:0] loc_cmpb_hi = 4'h5;
  localparam logic [3:0] loc_capt_lo = 4'h6;
  localparam logic [3:0] loc_capt_hi = 4'h7;
  localparam logic [3:0] loc_control_a = 4'h8;
  localparam logic [3:0] loc_control_b = 4'h9;
  localparam logic [3:0] loc_control_c = 4'hA;
  localparam logic [3:0] loc_flags = 4'hB;
  // field positions inside the control and flag bytes
  localparam int waveform_lo_pos = 0;
  localparam int waveform_bit2_pos = 3;
  localparam int waveform_bit3_pos = 4;
  localparam int force_a_pos = 7;
  localparam int force_b_pos = 6;
  localparam int overflow_pos = 0;
  // fixed ceilings and limits
  localparam logic [15:0] count_floor = 16'h0000;
  localparam logic [15:0] count_max = 16'hFFFF;
  localparam logic [15:0] top_8bit = 16'h00FF;
  localparam logic [15:0] top_9bit = 16'h01FF;
  localparam logic [15:0] top_10bit = 16'h03FF;
  // reset values
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [15:0] word_reset = 16'h0000;
  // apb register offsets of the controller
  localparam logic [11:0] apb_cmd_off = 12'h000;
  localparam logic [11:0] apb_status_off = 12'h004;
  localparam logic [11:0] apb_rdata_off = 12'h008;
endpackage

// *** inc/timer16_link_if.sv ***
// timer16_link_if: 8-bit byte bus between the controller and the timer
// assumes: one clock; a strobe lasts one cycle, read data is combinational
`timescale 1ns/1ns
`default_nettype none
interface timer16_link_if;
  logic [3:0] addr;
  logic wr_en;
  logic rd_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] tick_src;
  logic overflow_irq;
  modport timer (input addr, input wr_en, input rd_en, input wdata, input tick_src,
    output rdata, output overflow_irq);
  modport cpu (output addr, output wr_en, output rd_en, output wdata, output tick_src,
    input rdata, input overflow_irq);
endinterface
`default_nettype wire

// *** core/timer16_core.sv ***
// timer16_core: 16-bit up/down counter with shared high-byte holding register
// assumes: byte strobes and tick sources are synchronous to sys_clk
// What this block does
// RL1 - sixteen-bit registers move as two bytes
// RL2 - one high-byte holding register shared by all
// RL3 - low-byte write loads holding and low together
// RL4 - low-byte read copies high byte to holding
// RL5 - compare reads return own high byte
// RL6 - cpu writes high first, reads low first
// RL7 - main code masks interrupts around pairs
// RL8 - one high write may serve several lows
// RL9 - counter high location maps to holding register
// RL10 - three-bit tick select, zero stops counting
// RL11 - each tick clears, increments or decrements
// RL12 - counter accessible with or without ticks
// RL13 - cpu write beats clear and count
// RL14 - waveform mode split over control a, b
// RL15 - overflow flag set per mode, raises request
// RL16 - floor and ceiling indicators, clear forces zero
// RL17 - control c forces, control b mode bit3
// RL18 - floor when counter equals zero
// RL19 - max when counter is all ones
// RL20 - ceiling fixed or compare a or capture
// RL21 - reset clears counter, holding, select, flag
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module timer16_core
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // byte bus from the cpu end
  timer16_link_if.timer link,
  // capture event, unused otherwise
  input wire logic capture_strobe,
  // status out
  output logic count_floor_o,
  output logic count_ceiling_o,
  output logic count_max_o,
  output logic force_a_pulse,
  output logic force_b_pulse,
  output logic [15:0] counter_value_o
);
  logic [15:0] counter_value_q;
  logic [15:0] compare_value_a_q;
  logic [15:0] compare_value_b_q;
  logic [15:0] capture_value_q;
  logic [7:0] hold_q;
  logic [7:0] control_a_q;
  logic [7:0] control_b_q;
  logic overflow_flag_q;
  logic count_up_q;
  logic [3:0] waveform_mode_field;
  logic [2:0] clock_select_field;
  logic timer_tick;
  logic [15:0] top_value;
  logic at_top;
  logic at_floor;
  logic cpu_count_wr;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  assign waveform_mode_field = {control_b_q[waveform_bit3_pos], control_b_q[waveform_bit2_pos],
    control_a_q[waveform_lo_pos+1], control_a_q[waveform_lo_pos]}; // RL14 RL17
  assign clock_select_field = control_b_q[2:0];

  // true for the phase-correct modes that count down from top
  function automatic logic dual_slope(input logic [3:0] m);
    dual_slope = (m[3] == 1'b0 && m[2] == 1'b0 && m[1:0] != 2'b00) || (m[3:2] == 2'b10);
  endfunction

  always_comb begin
    case (waveform_mode_field) // RL20
      4'h1, 4'h5: top_value = top_8bit;
      4'h2, 4'h6: top_value = top_9bit;
      4'h3, 4'h7: top_value = top_10bit;
      4'h4, 4'h9, 4'hB, 4'hF: top_value = compare_value_a_q;
      4'h8, 4'hA, 4'hC, 4'hE: top_value = capture_value_q;
      default: top_value = count_max;
    endcase
  end

  // tick sources arrive prescaled from outside; select zero stops
  assign timer_tick = (clock_select_field != 3'h0) && link.tick_src[clock_select_field]; // RL10

  assign at_floor = (counter_value_q == count_floor); // RL18
  assign at_top = (counter_value_q == top_value);
  assign count_floor_o = at_floor; // RL16
  assign count_ceiling_o = at_top; // RL16
  assign count_max_o = (counter_value_q == count_max); // RL19
  assign counter_value_o = counter_value_q;
  assign link.overflow_irq = overflow_flag_q; // RL15
  assign cpu_count_wr = link.wr_en && (link.addr == loc_count_lo);

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      counter_value_q <= word_reset; // RL21
      count_up_q <= 1'b1;
    end else if (cpu_count_wr) begin
      counter_value_q <= {hold_q, link.wdata}; // RL3 RL13 RL12
    end else if (timer_tick) begin // RL11
      if (dual_slope(waveform_mode_field)) begin
        if (count_up_q && at_top) begin
          count_up_q <= 1'b0;
          counter_value_q <= counter_value_q - 16'h0001;
        end else if (!count_up_q && at_floor) begin
          count_up_q <= 1'b1;
          counter_value_q <= counter_value_q + 16'h0001;
        end else if (count_up_q) begin
          counter_value_q <= counter_value_q + 16'h0001;
        end else begin
          counter_value_q <= counter_value_q - 16'h0001;
        end
      end else if (at_top) begin
        counter_value_q <= count_floor; // RL16
        count_up_q <= 1'b1;
      end else begin
        counter_value_q <= counter_value_q + 16'h0001;
        count_up_q <= 1'b1;
      end
    end
  end

  // overflow: at top for single slope, at floor for dual slope
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overflow_flag_q <= 1'b0; // RL21
    end else if (timer_tick && !cpu_count_wr &&
      (dual_slope(waveform_mode_field) ? (at_floor && !count_up_q) : at_top)) begin
      overflow_flag_q <= 1'b1; // RL15
    end else if (link.wr_en && link.addr == loc_flags && link.wdata[overflow_pos]) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // byte access path
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_q <= 8'h00; // RL21
    end else if (link.wr_en && (link.addr == loc_count_hi || link.addr == loc_cmpa_hi ||
      link.addr == loc_cmpb_hi || link.addr == loc_capt_hi)) begin
      hold_q <= link.wdata; // RL2 RL9
    end else if (link.rd_en) begin
      case (link.addr) // RL4
        loc_count_lo: hold_q <= counter_value_q[15:8];
        loc_capt_lo: hold_q <= capture_value_q[15:8];
        default: hold_q <= hold_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      compare_value_a_q <= word_reset;
      compare_value_b_q <= word_reset;
    end else if (link.wr_en && link.addr == loc_cmpa_lo) begin
      compare_value_a_q <= {hold_q, link.wdata}; // RL3 RL1
    end else if (link.wr_en && link.addr == loc_cmpb_lo) begin
      compare_value_b_q <= {hold_q, link.wdata}; // RL3
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      capture_value_q <= word_reset;
    end else if (link.wr_en && link.addr == loc_capt_lo) begin
      capture_value_q <= {hold_q, link.wdata}; // RL3
    end else if (capture_strobe) begin
      capture_value_q <= counter_value_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_a_q <= control_reset;
      control_b_q <= control_reset; // RL21
    end else if (link.wr_en && link.addr == loc_control_a) begin
      control_a_q <= link.wdata;
    end else if (link.wr_en && link.addr == loc_control_b) begin
      control_b_q <= link.wdata;
    end
  end

  // force-compare bits are strobes; they read back as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      force_a_pulse <= 1'b0;
      force_b_pulse <= 1'b0;
    end else begin
      force_a_pulse <= link.wr_en && link.addr == loc_control_c && link.wdata[force_a_pos]; // RL17
      force_b_pulse <= link.wr_en && link.addr == loc_control_c && link.wdata[force_b_pos];
    end
  end

  always_comb begin
    case (link.addr)
      loc_count_lo: link.rdata = counter_value_q[7:0];
      loc_count_hi: link.rdata = hold_q; // RL9
      loc_cmpa_lo: link.rdata = compare_value_a_q[7:0];
      loc_cmpa_hi: link.rdata = compare_value_a_q[15:8]; // RL5
      loc_cmpb_lo: link.rdata = compare_value_b_q[7:0];
      loc_cmpb_hi: link.rdata = compare_value_b_q[15:8]; // RL5
      loc_capt_lo: link.rdata = capture_value_q[7:0];
      loc_capt_hi: link.rdata = hold_q;
      loc_control_a: link.rdata = control_a_q;
      loc_control_b: link.rdata = control_b_q;
      loc_flags: link.rdata = {7'h00, overflow_flag_q};
      default: link.rdata = 8'h00;
    endcase
  end
endmodule // timer16_core
`default_nettype wire

// *** core/timer16_cpu_end.sv ***
// timer16_cpu_end: apb-driven controller issuing byte accesses to the timer
// assumes: apb slave with zero wait states; software orders the pairs
`timescale 1ns/1ns
`default_nettype none
module timer16_cpu_end
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // prescaled tick sources from the system
  input wire logic [7:0] tick_in,
  // byte bus to the timer
  timer16_link_if.cpu link
);
  logic [7:0] rdata_q;
  logic apb_wr;
  logic cmd_hit;

  // one byte access per apb command write; software keeps the
  // high-then-low write and low-then-high read order and masks irqs
  assign apb_wr = psel && penable && pwrite;
  assign cmd_hit = apb_wr && paddr == apb_cmd_off;
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
    !(paddr == apb_cmd_off || paddr == apb_status_off || paddr == apb_rdata_off);

  // ------------------------------------------------------------
  // byte strobes: command word = {rd, wr, addr[11:8], data[7:0]}
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      link.addr <= 4'h0;
      link.wdata <= 8'h00;
      link.wr_en <= 1'b0;
      link.rd_en <= 1'b0;
    end else begin
      link.addr <= cmd_hit ? pwdata[11:8] : link.addr;
      link.wdata <= cmd_hit ? pwdata[7:0] : link.wdata;
      link.wr_en <= cmd_hit && pwdata[12]; // RL1 RL6 RL8
      link.rd_en <= cmd_hit && pwdata[13]; // RL6 RL7
    end
  end

  assign link.tick_src = tick_in;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (link.rd_en) begin
      rdata_q <= link.rdata;
    end
  end

  always_comb begin
    case (paddr)
      apb_status_off: prdata = {31'h0, link.overflow_irq};
      apb_rdata_off: prdata = {24'h0, rdata_q};
      default: prdata = 32'h0;
    endcase
  end
endmodule // timer16_cpu_end
`default_nettype wire

// *** testbench/timer16_checker.sv ***
// timer16_checker: link-level assertions for the byte-access timer
// assumes: instantiated beside the link interface, one clock domain
`timescale 1ns/1ns
`default_nettype none
module timer16_checker
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // byte link
  input wire logic [3:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [7:0] tick_src,
  input wire logic overflow_irq,
  // core status
  input wire logic [15:0] counter_value_o,
  input wire logic count_floor_o,
  input wire logic count_max_o
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------
  // shadow state
  // ----------
  logic [7:0] hold_q;
  logic [15:0] cmpa_q;
  logic [2:0] sel_q;
  logic [3:0] mode_q;
  logic run_up;
  // only normal mode is stepped here; other modes rest on the flag checks
  assign run_up = sel_q != 3'h0 && tick_src[sel_q] && mode_q == 4'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_q <= 8'h00;
      cmpa_q <= 16'h0000;
    end else if (wr_en && addr == loc_cmpa_lo) begin
      cmpa_q <= {hold_q, wdata};
    end else if (wr_en && addr[0] && !addr[3]) begin
      hold_q <= wdata;
    end else if (rd_en && addr == loc_count_lo) begin
      hold_q <= counter_value_o[15:8];
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_q <= 3'h0;
      mode_q <= 4'h0;
    end else if (wr_en && addr == loc_control_a) begin
      mode_q[1:0] <= wdata[1:0];
    end else if (wr_en && addr == loc_control_b) begin
      sel_q <= wdata[2:0];
      mode_q[3:2] <= wdata[4:3];
    end
  end
  // ----------
  // assertions
  // ----------
  a_floor_flag: assert property (count_floor_o == (counter_value_o == count_floor))
    else $error("floor flag wrong");
  a_max_flag: assert property (count_max_o == (counter_value_o == count_max))
    else $error("max flag wrong");
  a_low_write: assert property (wr_en && addr == loc_count_lo |=>
    counter_value_o == {$past(hold_q), $past(wdata)}) else $error("low write wrong");
  a_low_read: assert property (rd_en && addr == loc_count_lo |->
    rdata == counter_value_o[7:0]) else $error("low read wrong");
  a_high_temp: assert property (rd_en && addr == loc_count_hi |-> rdata == hold_q)
    else $error("high read not from holding");
  a_cmp_own: assert property (rd_en && addr == loc_cmpa_hi |-> rdata == cmpa_q[15:8])
    else $error("compare high read wrong");
  a_stopped_hold: assert property (sel_q == 3'h0 && !(wr_en && addr == loc_count_lo) |=>
    $stable(counter_value_o)) else $error("counter moved while stopped");
  a_count_up: assert property (run_up && !wr_en |=>
    counter_value_o == $past(counter_value_o) + 16'h0001) else $error("count step wrong");
  a_overflow_set: assert property (run_up && !wr_en && counter_value_o == count_max |->
    ##[1:2] overflow_irq) else $error("overflow not flagged");
  a_flag_clear: assert property (wr_en && addr == loc_flags && wdata[0] && sel_q == 3'h0 |=>
    !overflow_irq) else $error("flag not cleared");
  a_reset_clear: assert property (disable iff (1'b0) rst |->
    counter_value_o == word_reset && !overflow_irq) else $error("reset state wrong");
  a_dual_bound: assert property (sel_q != 3'h0 && mode_q == 4'h1 |->
    counter_value_o <= top_8bit) else $error("dual slope passed its top");
  c_wrap: cover property (run_up && counter_value_o == count_max ##1 overflow_irq);
  c_dual_turn: cover property (sel_q != 3'h0 && mode_q == 4'h1 && counter_value_o == top_8bit);
  c_cmp_read: cover property (rd_en && addr == loc_cmpa_hi);
  c_busy_write: cover property (wr_en && addr == loc_count_lo && sel_q != 3'h0);
endmodule // timer16_checker
`default_nettype wire

// *** testbench/timer16_byte_access_counter_tb.sv ***
// timer16_byte_access_counter_tb: apb bench for both timer ends joined by the link
// assumes: package, link interface, both ends and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module timer16_byte_access_counter_tb
  import timer16_pkg::*;
;
  logic sys_clk;
  logic rst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] tick_in = 8'h00;
  logic capture_strobe = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, err_seen;
  logic count_floor_o, count_ceiling_o, count_max_o, force_a_pulse, force_b_pulse;
  logic [15:0] counter_value_o;
  logic [15:0] fa_n = 16'h0000, fb_n = 16'h0000;
  logic [31:0] seed = 32'hE3C3281B;
  logic [31:0] exp_q[$], mask_q[$];
  int failures = 0, checks_done = 0;
  timer16_link_if link ();
  timer16_cpu_end i_timer16_cpu_end (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tick_in(tick_in), .link(link));
  timer16_core i_timer16_core (.sys_clk(sys_clk), .rst(rst), .link(link),
    .capture_strobe(capture_strobe), .count_floor_o(count_floor_o),
    .count_ceiling_o(count_ceiling_o), .count_max_o(count_max_o),
    .force_a_pulse(force_a_pulse), .force_b_pulse(force_b_pulse),
    .counter_value_o(counter_value_o));
  timer16_checker i_timer16_checker (.sys_clk(sys_clk), .rst(rst), .addr(link.addr),
    .wr_en(link.wr_en), .rd_en(link.rd_en), .wdata(link.wdata), .rdata(link.rdata),
    .tick_src(link.tick_src), .overflow_irq(link.overflow_irq),
    .counter_value_o(counter_value_o), .count_floor_o(count_floor_o),
    .count_max_o(count_max_o));
  // ----------
  // stimulus helpers
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    seed = xs(seed);
    tick_in <= seed[7:0];
    capture_strobe <= seed[8];
    if (force_a_pulse === 1'b1) fa_n <= fa_n + 16'h0001;
    if (force_b_pulse === 1'b1) fb_n <= fb_n + 16'h0001;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic rd, input logic wr, input logic [3:0] loc, input logic [7:0] d);
    apb(1'b1, apb_cmd_off, {18'h00000, rd, wr, loc, d});
  endtask
  task automatic wr16(input logic [15:0] v);
    cmd(1'b0, 1'b1, loc_count_hi, v[15:8]);
    cmd(1'b0, 1'b1, loc_count_lo, v[7:0]);
  endtask
  task automatic expect_rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    mask_q.push_back(m);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic rdb(input logic [3:0] loc, input logic [7:0] e);
    cmd(1'b1, 1'b0, loc, 8'h00);
    expect_rd(apb_rdata_off, 32'h000000FF, {24'h000000, e});
  endtask
  // taken at the edge that ends the access, before anything at that edge updates
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk(prdata & mask_q.pop_front(), exp_q.pop_front());
    end
  end
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------
  // scenarios
  // ----------
  initial begin
    #1 rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rdb(loc_count_lo, 8'h00);
    expect_rd(apb_status_off, 32'h00000001, 32'h00000000);
    wr16(16'h01FF);
    rdb(loc_count_lo, 8'hFF);
    rdb(loc_count_hi, 8'h01);
    cmd(1'b0, 1'b1, loc_cmpa_hi, 8'hA5);
    cmd(1'b0, 1'b1, loc_cmpa_lo, 8'h3C);
    cmd(1'b0, 1'b1, loc_cmpb_lo, 8'hC3);
    rdb(loc_count_lo, 8'hFF);
    rdb(loc_cmpa_hi, 8'hA5);
    rdb(loc_cmpb_lo, 8'hC3);
    rdb(loc_count_hi, 8'h01);
    cmd(1'b0, 1'b1, loc_cmpb_hi, 8'h77);
    rdb(loc_count_hi, 8'h77);
    rdb(4'hF, 8'h00);
    wr16(16'hFFF0);
    for (int s = 1; s < 8; s++) begin
      cmd(1'b0, 1'b1, loc_control_b, {5'h00, s[2:0]});
      repeat (20) @(posedge sys_clk);
    end
    wr16(16'hABCD);
    cmd(1'b0, 1'b1, loc_control_b, 8'h00);
    expect_rd(apb_status_off, 32'h00000001, 32'h00000001);
    cmd(1'b0, 1'b1, loc_flags, 8'h01);
    expect_rd(apb_status_off, 32'h00000001, 32'h00000000);
    wr16(16'h1234);
    repeat (30) @(posedge sys_clk);
    rdb(loc_count_lo, 8'h34);
    rdb(loc_count_hi, 8'h12);
    // a stopped counter is copied by the random capture strobe
    rdb(loc_capt_lo, 8'h34);
    rdb(loc_capt_hi, 8'h12);
    for (int m = 1; m < 8; m++) begin
      cmd(1'b0, 1'b1, loc_control_a, {6'h00, m[1:0]});
      cmd(1'b0, 1'b1, loc_control_b, {3'h0, 1'b0, m[2], 3'h0});
      wr16(m == 4 ? 16'hA53C : m[1:0] == 2'h1 ? top_8bit :
        m[1:0] == 2'h2 ? top_9bit : top_10bit);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({31'h00000000, count_ceiling_o}, 32'h00000001);
    end
    // dual slope with an 8-bit top: no flag at the top, flag once back at the floor
    cmd(1'b0, 1'b1, loc_control_a, 8'h01);
    wr16(16'h00FE);
    cmd(1'b0, 1'b1, loc_control_b, 8'h01);
    repeat (40) @(posedge sys_clk);
    expect_rd(apb_status_off, 32'h00000001, 32'h00000000);
    repeat (700) @(posedge sys_clk);
    cmd(1'b0, 1'b1, loc_control_b, 8'h00);
    expect_rd(apb_status_off, 32'h00000001, 32'h00000001);
    cmd(1'b0, 1'b1, loc_control_c, 8'h80);
    cmd(1'b0, 1'b1, loc_control_c, 8'h40);
    repeat (3) @(posedge sys_clk);
    chk({fa_n, fb_n}, 32'h00010001);
    apb(1'b1, 12'h010, 32'h00000000);
    chk({31'h00000000, err_seen}, 32'h00000001);
    final_report();
  end
  // the run needs under 2000 cycles; this margin only catches a hung handshake
  initial begin
    #200000;
    failures++;
    final_report();
  end
endmodule // timer16_byte_access_counter_tb
`default_nettype wire
